// >>> core/xbus_pkg.sv
package xbus_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_RTIME     = 8'h04;
  localparam logic [7:0] ADDR_WTIME     = 8'h08;
  localparam logic [7:0] ADDR_ADDR      = 8'h0C;
  localparam logic [7:0] ADDR_WDATA     = 8'h10;
  localparam logic [7:0] ADDR_RDATA     = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  localparam logic [7:0] ADDR_HOST_DATA = 8'h1C;
  localparam logic [7:0] ADDR_HOST_IN   = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // CTRL
  localparam int CTRL_GO_BIT     = 0;
  localparam int CTRL_WRITE_BIT  = 1;
  localparam int CTRL_RDY_EN_BIT = 2;
  localparam int CTRL_HOST_BIT   = 3;
  localparam int CTRL_SPACE_LSB  = 4;
  // Timing registers: setup [3:0], strobe [9:4], hold [13:10]
  localparam int TIM_SETUP_LSB   = 0;
  localparam int TIM_STROBE_LSB  = 4;
  localparam int TIM_HOLD_LSB    = 10;
  // STATUS
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_HWR_BIT    = 2;
  localparam int STAT_HRD_BIT    = 3;
  localparam int STAT_STATE_LSB  = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] RTIME_RST = 32'h0000_0411;
  localparam logic [31:0] WTIME_RST = 32'h0000_0411;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RDY_END_MIN_P   = 3;
  localparam int CE_TAIL_P       = 7;
  localparam int HRDY_REL_P      = 2;
  localparam int HDATA_REL_P     = 4;
  localparam int CE_TAIL_CYC     = CE_TAIL_P;
  localparam int HRDY_REL_CYC    = HRDY_REL_P;
  localparam int HDATA_REL_CYC   = HDATA_REL_P - 1;
  localparam int RDY_EXT_MIN_SUM = 4;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_WAIT   = 5'b01000,
    ST_HOLD   = 5'b10000
  } cyc_state_t;

endpackage

// >>> core/xbus_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module xbus_host_port
  import xbus_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Host pins
  input  wire logic        i_host_select_n,
  input  wire logic        i_host_addr_strobe,
  input  wire logic        i_host_ctl_select,
  input  wire logic        i_host_direction,
  input  wire logic        i_burst_last,
  input  wire logic [3:0]  i_byte_lane_n,
  input  wire logic [31:0] i_data,
  // Boot polarity straps
  input  wire logic        i_dir_pol,
  input  wire logic        i_blast_pol,
  // Read data and capture
  input  wire logic [31:0] i_read_word,
  output logic             o_wr_stb,
  output logic             o_rd_stb,
  output logic [31:0]      o_wr_data,
  output logic [3:0]       o_wr_be,
  output logic             o_wr_ctl,
  // Pin drives
  output logic             o_ready_n_o,
  output logic             o_ready_oe_n,
  output logic [31:0]      o_data_o,
  output logic             o_data_oe_n
);

  logic       access;
  logic       is_write;
  logic       is_last;
  logic [1:0] rdy_cnt_q;
  logic [1:0] dat_cnt_q;
  logic       dir_pol_q;
  logic       blast_pol_q;
  logic       pol_taken_q;

  // ****************************************************************
  // Boot-time polarity capture
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pol_taken_q <= 1'b0;
      dir_pol_q   <= 1'b0;
      blast_pol_q <= 1'b0;
    end else if (!pol_taken_q) begin
      pol_taken_q <= 1'b1;
      dir_pol_q   <= i_dir_pol;
      blast_pol_q <= i_blast_pol;
    end
  end

  assign access   = !i_host_select_n && i_host_addr_strobe;
  assign is_write = (i_host_direction == dir_pol_q);
  assign is_last  = (i_burst_last == blast_pol_q);

  // ****************************************************************
  // Capture strobes
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wr_stb  <= 1'b0;
      o_rd_stb  <= 1'b0;
      o_wr_data <= 32'h0000_0000;
      o_wr_be   <= 4'h0;
      o_wr_ctl  <= 1'b0;
    end else begin
      o_wr_stb <= access && is_write;
      o_rd_stb <= access && !is_write;
      if (access && is_write) begin
        o_wr_data <= i_data;
        o_wr_be   <= ~i_byte_lane_n;
        o_wr_ctl  <= i_host_ctl_select;
      end
    end
  end

  // ****************************************************************
  // Ready drive and release
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ready_n_o  <= 1'b1;
      o_ready_oe_n <= 1'b1;
      rdy_cnt_q    <= 2'd0;
    end else if (access) begin
      o_ready_n_o  <= 1'b0;
      o_ready_oe_n <= 1'b0;
      rdy_cnt_q    <= 2'(HRDY_REL_CYC);
    end else if (rdy_cnt_q != 2'd0) begin
      o_ready_n_o <= 1'b1;
      rdy_cnt_q   <= rdy_cnt_q - 2'd1;
      if (rdy_cnt_q == 2'd1) begin
        o_ready_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read data drive and release
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_data_o    <= 32'h0000_0000;
      o_data_oe_n <= 1'b1;
      dat_cnt_q   <= 2'd0;
    end else if (access && !is_write) begin
      o_data_o    <= i_read_word;
      o_data_oe_n <= 1'b0;
      dat_cnt_q   <= is_last ? 2'(HDATA_REL_CYC) : 2'd0;
    end else if (dat_cnt_q != 2'd0) begin
      dat_cnt_q <= dat_cnt_q - 2'd1;
      if (dat_cnt_q == 2'd1) begin
        o_data_oe_n <= 1'b1;
      end
    end else if (!o_data_oe_n && !access) begin
      o_data_oe_n <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> core/xbus_async_port.sv
`timescale 1ns/1ps
`default_nettype none
module xbus_async_port
  import xbus_pkg::*;
#(
  parameter int SPACES = 4
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // AXI4-Lite write address, data and response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Async peripheral pins
  output logic [SPACES-1:0] o_space_enable_n,
  output logic              o_periph_output_enable_n,
  output logic              o_periph_read_strobe_n,
  output logic              o_write_strobe_or_wait_n,
  output logic [3:0]        o_byte_lane_or_addr_low,
  input  wire logic         i_exp_ready,
  output logic              o_exp_ready_n_o,
  output logic              o_exp_ready_oe_n,
  // Data bus
  input  wire logic [31:0]  i_exp_data_bus,
  output logic [31:0]       o_exp_data_bus,
  output logic              o_exp_data_bus_oe_n,
  // Host port pins
  input  wire logic         i_host_select_n,
  input  wire logic         i_host_addr_strobe,
  input  wire logic         i_host_ctl_select,
  input  wire logic         i_host_direction,
  input  wire logic         i_burst_last,
  input  wire logic [3:0]   i_byte_lane_n,
  input  wire logic         i_dir_pol,
  input  wire logic         i_blast_pol
);

  cyc_state_t  state_q;
  logic [31:0] ctrl_q, rtime_q, wtime_q, addr_q, wdata_q, rdata_q, host_data_q;
  logic [31:0] host_in_q;
  logic        done_q, hwr_q, hrd_q;
  logic [5:0]  cnt_q;
  logic [2:0]  tail_q;
  logic        rdy_s1_q, rdy_s2_q;
  logic        is_wr_q, rdy_en_q;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wbuf_q;
  logic [3:0]  wstrb_q;
  logic        go_pulse;
  logic [31:0] tim;
  logic        h_wr_stb, h_rd_stb;
  logic [31:0] h_wr_data, h_data_o;
  logic [3:0]  h_be;
  logic        h_rdy, h_rdy_oe_n, h_data_oe_n;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [5:0] fld(input logic [31:0] t, input int lsb, input int w);
    return 6'((t >> lsb) & ((32'd1 << w) - 32'd1));
  endfunction

  // ****************************************************************
  // AXI4-Lite write
  // ****************************************************************
  assign go_pulse = aw_q && w_q && !s_axi_bvalid && (awaddr_q == ADDR_CTRL)
                    && wstrb_q[0] && wbuf_q[CTRL_GO_BIT] && (state_q == ST_IDLE);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= 8'h00; wbuf_q <= 32'h0; wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= AXI_OKAY;
      ctrl_q <= CTRL_RST; rtime_q <= RTIME_RST; wtime_q <= WTIME_RST;
      addr_q <= 32'h0; wdata_q <= 32'h0; host_data_q <= 32'h0;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_q <= 1'b1; awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_q <= 1'b1; wbuf_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb;
      end
      if (aw_q && w_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= AXI_OKAY;
        case (awaddr_q)
          ADDR_CTRL: ctrl_q <= merge(ctrl_q, wbuf_q & ~32'h1, wstrb_q);
          ADDR_RTIME: rtime_q <= merge(rtime_q, wbuf_q, wstrb_q);
          ADDR_WTIME: wtime_q <= merge(wtime_q, wbuf_q, wstrb_q);
          ADDR_ADDR: addr_q <= merge(addr_q, wbuf_q, wstrb_q);
          ADDR_WDATA: wdata_q <= merge(wdata_q, wbuf_q, wstrb_q);
          ADDR_HOST_DATA: host_data_q <= merge(host_data_q, wbuf_q, wstrb_q);
          ADDR_RDATA, ADDR_STATUS, ADDR_HOST_IN: s_axi_bresp <= AXI_OKAY;
          default: s_axi_bresp <= AXI_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; aw_q <= 1'b0; w_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0; s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= AXI_OKAY;
        case (s_axi_araddr)
          ADDR_CTRL: s_axi_rdata <= ctrl_q;
          ADDR_RTIME: s_axi_rdata <= rtime_q;
          ADDR_WTIME: s_axi_rdata <= wtime_q;
          ADDR_ADDR: s_axi_rdata <= addr_q;
          ADDR_WDATA: s_axi_rdata <= wdata_q;
          ADDR_RDATA: s_axi_rdata <= rdata_q;
          ADDR_STATUS: s_axi_rdata <= {19'h0, state_q, 4'h0, hrd_q, hwr_q, done_q, (state_q != ST_IDLE)};
          ADDR_HOST_DATA: s_axi_rdata <= host_data_q;
          ADDR_HOST_IN: s_axi_rdata <= host_in_q;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status flags, set wins over clear
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      done_q <= 1'b0; hwr_q <= 1'b0; hrd_q <= 1'b0; host_in_q <= 32'h0;
    end else begin
      if (state_q == ST_HOLD && cnt_q <= 6'd1) done_q <= 1'b1;
      else if (go_pulse) done_q <= 1'b0;
      if (h_wr_stb) begin
        hwr_q <= 1'b1;
        host_in_q <= merge(host_in_q, h_wr_data, h_be);
      end else if (s_axi_arready && s_axi_arvalid && s_axi_araddr == ADDR_HOST_IN) hwr_q <= 1'b0;
      if (h_rd_stb) hrd_q <= 1'b1;
      else if (s_axi_arready && s_axi_arvalid && s_axi_araddr == ADDR_STATUS) hrd_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Ready synchroniser
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= i_exp_ready;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // ****************************************************************
  // Async peripheral cycle engine
  // ****************************************************************
  assign tim = is_wr_q ? wtime_q : rtime_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= ST_IDLE; cnt_q <= 6'd0; is_wr_q <= 1'b0; rdy_en_q <= 1'b0; rdata_q <= 32'h0;
    end else begin
      case (state_q)
        ST_IDLE: if (go_pulse) begin
          is_wr_q  <= wbuf_q[CTRL_WRITE_BIT];
          // Extension only honoured when setup plus strobe reaches the minimum
          rdy_en_q <= wbuf_q[CTRL_RDY_EN_BIT] && ((wbuf_q[CTRL_WRITE_BIT] ?
                      ({1'b0, fld(wtime_q, TIM_SETUP_LSB, 4)} + {1'b0, fld(wtime_q, TIM_STROBE_LSB, 6)}) :
                      ({1'b0, fld(rtime_q, TIM_SETUP_LSB, 4)} + {1'b0, fld(rtime_q, TIM_STROBE_LSB, 6)}))
                      >= 7'(RDY_EXT_MIN_SUM));
          cnt_q    <= wbuf_q[CTRL_WRITE_BIT] ? fld(wtime_q, TIM_SETUP_LSB, 4)
                                             : fld(rtime_q, TIM_SETUP_LSB, 4);
          state_q  <= ST_SETUP;
        end
        ST_SETUP: if (cnt_q <= 6'd1) begin
          cnt_q   <= fld(tim, TIM_STROBE_LSB, 6);
          state_q <= ST_STROBE;
        end else cnt_q <= cnt_q - 6'd1;
        ST_STROBE: if (cnt_q <= 6'd1) begin
          if (rdy_en_q && !rdy_s2_q) state_q <= ST_WAIT;
          else begin
            if (!is_wr_q) rdata_q <= i_exp_data_bus;
            cnt_q   <= fld(tim, TIM_HOLD_LSB, 4);
            state_q <= ST_HOLD;
          end
        end else cnt_q <= cnt_q - 6'd1;
        ST_WAIT: begin
          if (rdy_s2_q) begin
            // Straight to hold keeps strobe end within four periods of ready
            if (!is_wr_q) rdata_q <= i_exp_data_bus;
            cnt_q   <= fld(tim, TIM_HOLD_LSB, 4);
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: if (cnt_q <= 6'd1) state_q <= ST_IDLE;
          else cnt_q <= cnt_q - 6'd1;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_space_enable_n <= '1; tail_q <= 3'd0;
      o_periph_output_enable_n <= 1'b1; o_periph_read_strobe_n <= 1'b1;
      o_write_strobe_or_wait_n <= 1'b1; o_byte_lane_or_addr_low <= 4'h0;
      o_exp_data_bus <= 32'h0; o_exp_data_bus_oe_n <= 1'b1;
      o_exp_ready_n_o <= 1'b1; o_exp_ready_oe_n <= 1'b1;
    end else begin
      o_exp_ready_n_o  <= h_rdy;
      o_exp_ready_oe_n <= h_rdy_oe_n;
      if (state_q != ST_IDLE) begin
        o_space_enable_n <= ~(SPACES'(1) << ctrl_q[CTRL_SPACE_LSB +: 2]);
        tail_q <= 3'(CE_TAIL_CYC - 1);
      end else if (tail_q != 3'd0) tail_q <= tail_q - 3'd1;
      else o_space_enable_n <= '1;
      o_byte_lane_or_addr_low  <= (state_q != ST_IDLE) ? addr_q[5:2] : 4'h0;
      o_periph_output_enable_n <= !((state_q != ST_IDLE) && !is_wr_q);
      o_periph_read_strobe_n   <= !((state_q == ST_STROBE || state_q == ST_WAIT) && !is_wr_q);
      o_write_strobe_or_wait_n <= !((state_q == ST_STROBE || state_q == ST_WAIT) && is_wr_q);
      if (state_q != ST_IDLE && is_wr_q) begin
        o_exp_data_bus <= wdata_q;
        o_exp_data_bus_oe_n <= 1'b0;
      end else begin
        o_exp_data_bus <= h_data_o;
        o_exp_data_bus_oe_n <= h_data_oe_n;
      end
    end
  end

  xbus_host_port xbus_host_port_inst (
    .i_mclk            (i_mclk),
    .i_rst             (i_rst),
    .i_host_select_n   (i_host_select_n),
    .i_host_addr_strobe(i_host_addr_strobe && ctrl_q[CTRL_HOST_BIT]),
    .i_host_ctl_select (i_host_ctl_select),
    .i_host_direction  (i_host_direction),
    .i_burst_last      (i_burst_last),
    .i_byte_lane_n     (i_byte_lane_n),
    .i_data            (i_exp_data_bus),
    .i_dir_pol         (i_dir_pol),
    .i_blast_pol       (i_blast_pol),
    .i_read_word       (host_data_q),
    .o_wr_stb          (h_wr_stb),
    .o_rd_stb          (h_rd_stb),
    .o_wr_data         (h_wr_data),
    .o_wr_be           (h_be),
    .o_wr_ctl          (),
    .o_ready_n_o       (h_rdy),
    .o_ready_oe_n      (h_rdy_oe_n),
    .o_data_o          (h_data_o),
    .o_data_oe_n       (h_data_oe_n)
  );

endmodule
`default_nettype wire

// >>> tb/xbus_properties.sv
`timescale 1ns/1ps
`default_nettype none
module xbus_chk #(
  parameter int SPACES = 4
) (
  // Clock and reset
  input wire logic              i_mclk,
  input wire logic              i_rst,
  // Expansion pins
  input wire logic [SPACES-1:0] o_space_enable_n,
  input wire logic              o_periph_read_strobe_n,
  input wire logic              o_write_strobe_or_wait_n,
  input wire logic [3:0]        o_byte_lane_or_addr_low,
  input wire logic [31:0]       o_exp_data_bus,
  input wire logic              o_exp_data_bus_oe_n,
  input wire logic              o_exp_ready_n_o,
  input wire logic              o_exp_ready_oe_n
);
  // ****************************************************************
  // Pin relations
  // ****************************************************************
  wire logic rd = !o_periph_read_strobe_n;
  wire logic wr = !o_write_strobe_or_wait_n;
  wire logic ce = !(&o_space_enable_n);
  wire logic doe = !o_exp_data_bus_oe_n;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  strobe_excl_a: assert property (!(rd && wr)) else $error("both strobes low");
  rd_setup_a: assert property ($rose(rd) |-> $past(ce)) else $error("read strobe without setup");
  rd_hold_a: assert property ($fell(rd) |-> ce) else $error("read select dropped early");
  wr_setup_a: assert property ($rose(wr) |-> $past(ce && doe)) else $error("write without setup");
  wr_data_a: assert property (wr && $past(wr) |-> doe && $stable(o_exp_data_bus)) else $error("write data moved");
  wr_hold_a: assert property ($fell(wr) |-> ce && doe) else $error("write hold missing");
  addr_stable_a: assert property (rd && $past(rd) |-> $stable(o_byte_lane_or_addr_low)) else $error("addr moved");
  ce_release_a: assert property ($fell(rd) || $fell(wr) |-> ##[1:40] !ce) else $error("space stuck");
  host_rdy_a: assert property ($fell(o_exp_ready_oe_n) |-> !o_exp_ready_n_o ##[1:3] o_exp_ready_oe_n)
    else $error("host ready not released");
  rd_seen_c: cover property ($rose(rd));
  wr_seen_c: cover property ($rose(wr));
  host_seen_c: cover property ($fell(o_exp_ready_oe_n));
endmodule
bind xbus_async_port xbus_chk #(.SPACES(SPACES)) xbus_chk_inst (.*);
`default_nettype wire

// >>> tb/xbus_periph.sv
`timescale 1ns/1ps
`default_nettype none
module xbus_periph (
  // Peripheral side pins
  input  wire logic        i_mclk,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_oe_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_data,
  input  wire logic [7:0]  i_rdy_dly,
  output logic             o_ready,
  output logic [31:0]      o_data
);
  logic [31:0] mem_q [16];
  logic [31:0] last_q;
  logic [7:0]  cnt_q;
  wire logic   act = !(i_rd_n && i_wr_n);
  always_ff @(posedge i_mclk) begin
    cnt_q <= act ? cnt_q + 8'h01 : 8'h00;
    o_ready <= act && cnt_q >= i_rdy_dly;
    if (!i_wr_n)
      mem_q[i_addr] <= i_data;
    if (!i_oe_n)
      last_q <= mem_q[i_addr];
  end
  // Released bus shows the inverse of the last word
  assign o_data = i_oe_n ? ~last_q : mem_q[i_addr];
endmodule
`default_nettype wire

// >>> tb/xbus_async_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module xbus_async_port_test
  import xbus_pkg::*;
;
  logic        i_mclk = 0, i_rst = 1, i_exp_ready, host_drv = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rdy_dly = 8'hFF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, o_exp_data_bus, i_exp_data_bus, host_d = 0, pdata, rd_v;
  logic [3:0]  s_axi_wstrb = 4'hF, o_space_enable_n, o_byte_lane_or_addr_low, i_byte_lane_n = 0, ce_s, lane_s;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_exp_data_bus_oe_n;
  logic        o_periph_output_enable_n, o_periph_read_strobe_n, o_write_strobe_or_wait_n;
  logic        o_exp_ready_n_o, o_exp_ready_oe_n, i_host_select_n = 1, i_host_addr_strobe = 0;
  logic        i_host_ctl_select = 0, i_host_direction = 0, i_burst_last = 0, i_dir_pol = 0, i_blast_pol = 0;
  int          n_mismatch = 0, compares = 0, wid, su, rw, seed = 30;
  xbus_async_port #(.SPACES(4)) xbus_async_port_inst (.*);
  xbus_periph xbus_periph_inst (.i_mclk, .i_rd_n(o_periph_read_strobe_n), .i_wr_n(o_write_strobe_or_wait_n),
    .i_oe_n(o_periph_output_enable_n), .i_addr(o_byte_lane_or_addr_low), .i_data(i_exp_data_bus),
    .i_rdy_dly(rdy_dly), .o_ready(i_exp_ready), .o_data(pdata));
  assign i_exp_data_bus = !o_exp_data_bus_oe_n ? o_exp_data_bus : host_drv ? host_d : pdata;
  always #25 i_mclk = ~i_mclk;
  // ****************************************************************
  // Strobe monitor
  // ****************************************************************
  always @(posedge i_mclk) begin
    if (!(o_periph_read_strobe_n && o_write_strobe_or_wait_n)) begin
      wid <= wid + 1;
      ce_s <= o_space_enable_n;
      lane_s <= o_byte_lane_or_addr_low;
      rw <= rw + int'(i_exp_ready);
    end else if (!(&o_space_enable_n) && wid == 0)
      su <= su + 1;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n, lim);
    if (n >= lim) begin
      n_mismatch++;
      finish_test;
    end
  endtask
  function automatic int eff(input int x);
    return x == 0 ? 1 : x;
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge i_mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 64);
    rsp = s_axi_bresp;
    tmo(n, 64);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge i_mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 64);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    tmo(n, 64);
  endtask
  task automatic cyc(input logic w, re, input logic [1:0] sp, input logic [3:0] s, h, input logic [5:0] t,
                     input logic [7:0] a, input logic [31:0] d);
    int n;
    axi_wr(w ? ADDR_WTIME : ADDR_RTIME, {18'h0, h, t, s});
    axi_wr(ADDR_ADDR, {24'h0, a});
    axi_wr(ADDR_WDATA, d);
    for (n = 0; n < 40 && !(&o_space_enable_n); n++)
      @(posedge i_mclk);
    tmo(n, 40);
    @(negedge i_mclk);
    wid = 0;
    su = 0;
    rw = 0;
    @(posedge i_mclk);
    axi_wr(ADDR_CTRL, {26'h0, sp, 1'h0, re, w, 1'h1});
    n = 0;
    do begin
      axi_rd(ADDR_STATUS);
      n++;
    end while ((rd_v[STAT_BUSY_BIT] || wid == 0) && n < 200);
    tmo(n, 200);
    chk(rd_v[STAT_DONE_BIT], 1);
    chk(su, eff(s));
    chk(ce_s, 4'(~(4'h1 << sp)));
    chk(lane_s, a[5:2]);
    if (re) chk((rw == RDY_END_MIN_P || rw == RDY_END_MIN_P + 1) && wid > t, 1);
    else chk(wid, eff(t));
  endtask
  task automatic host(input logic wr, input logic [31:0] d);
    int n;
    i_host_select_n <= 1'h0;
    i_host_addr_strobe <= 1'h1;
    i_host_direction <= wr ? i_dir_pol : !i_dir_pol;
    i_burst_last <= i_blast_pol;
    host_d <= d;
    host_drv <= wr;
    @(posedge i_mclk);
    i_host_select_n <= 1'h1;
    i_host_addr_strobe <= 1'h0;
    i_burst_last <= !i_blast_pol;
    host_drv <= 1'h0;
    for (n = 0; n < 8 && o_exp_data_bus_oe_n; n++)
      @(posedge i_mclk);
    if (!wr) begin
      tmo(n, 8);
      chk(o_exp_data_bus, d);
      for (n = 0; n < 5 && !o_exp_data_bus_oe_n; n++)
        @(posedge i_mclk);
      tmo(n, 5);
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r, d;
    logic        re;
    for (int p = 0; p < 2; p++) begin
      i_dir_pol <= p[0];
      i_blast_pol <= !p[0];
      i_rst <= 1'h1;
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'h0;
      @(posedge i_mclk);
      if (p == 0) begin
        axi_rd(ADDR_RTIME);
        chk(rd_v, RTIME_RST);
        axi_rd(ADDR_WTIME);
        chk(rd_v, WTIME_RST);
        axi_rd(8'h3C);
        chk(rsp, AXI_SLVERR);
        axi_wr(8'h3C, 32'h0);
        chk(rsp, AXI_SLVERR);
        for (int i = 0; i < 6; i++) begin
          r = $random(seed);
          d = $random(seed);
          re = i > 3;
          rdy_dly <= re ? 8'h08 : 8'hFF;
          cyc(1'h1, re, r[5:4], i == 0 ? 4'h0 : re ? 4'h1 : {2'h0, r[1:0]}, {2'h0, r[7:6]},
              i == 0 ? 6'h3F : re ? 6'h03 : {4'h0, r[3:2]}, r[15:8], d);
          cyc(1'h0, re, r[5:4], re ? 4'h1 : 4'h2, 4'h1, re ? 6'h03 : {4'h0, r[3:2]}, r[15:8], 32'h0);
          axi_rd(ADDR_RDATA);
          chk(rd_v, d);
        end
      end
      axi_wr(ADDR_CTRL, 32'h8);
      d = $random(seed);
      axi_wr(ADDR_HOST_DATA, d);
      host(1'h0, d);
      d = $random(seed);
      host(1'h1, d);
      axi_rd(ADDR_STATUS);
      chk(rd_v[STAT_HRD_BIT:STAT_HWR_BIT], 2'h3);
      axi_rd(ADDR_HOST_IN);
      chk(rd_v, d);
    end
    finish_test;
  end
endmodule
`default_nettype wire
